/* hw/ucr_usb_control.sv */
/*
 * USB control register: enable, ping-pong reset, live single-ended-zero
 * flag, packet lockout on SETUP, resume and suspend controls.
 * Assumes a plain register port on clk with read data one cycle later,
 * an interface engine that reports SETUP tokens as one-cycle pulses and
 * a bus single-ended-zero level arriving asynchronously from the pins.
 */
// Added by the designer: the plain strobed port.
// Behaviour
// RULE1: Bits 7 and 0 read as zero
// RULE2: Ping-pong reset forces pointers to even bank
// RULE3: Firmware clears ping-pong reset itself
// RULE4: Ping-pong reset ignored without ping-pong mode
// RULE5: Bit 5 shows live single-ended zero
// RULE6: SETUP sets packet disable, halting engine
// RULE7: Packet disable only clearable by firmware
// RULE8: Status FIFO stays readable while disabled
// RULE9: Module enable attaches, clear detaches
// RULE10: Firmware configures USB clock before enable
// RULE11: Resume bit drives resume signalling
// RULE12: Firmware holds resume for 10 ms
// RULE13: Suspend stops engine clock, low power
// RULE14: Suspend follows idle, clears after activity
// RULE15: Suspended device stays attached, outputs idle
// RULE16: No suspend before a bus-idle request
// RULE17: Enable clears indicators, turns on pull-ups
// RULE18: Firmware clears suspend before disabling
// RULE19: Single-ended zero synchronised before reading
`default_nettype none
module ucr_usb_control (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // Register port
   input  wire ucr_pkg::ucr_bus_req_t busReq,
   output logic [7:0]               rdata,
   // Interface engine and configuration
   input  wire logic                setupToken,
   input  wire logic [1:0]          pingpongMode,
   input  wire logic                pullupEnable,
   input  wire logic                statusFifoPending,
   output logic                     statusFifoReadable,
   // Bus condition from the pins
   input  wire logic                busSe0,
   // Controls to engine and transceiver
   output ucr_pkg::ucr_ctrl_t       ctrl
);
   logic       ppReset_q;
   logic       pktDisable_q;
   logic       modEnable_q;
   logic       resume_q;
   logic       suspend_q;
   logic       enablePrev_q;
   logic [2:0] se0Sync_q;
   logic       se0Live_q;
   logic [7:0] rdata_q;
   logic       ctrlWrite;
   logic [7:0] readValue;

   assign ctrlWrite = busReq.wr &&
                      (busReq.addr == ucr_pkg::USB_CONTROL_OFS);

   // Plain writable bits; no self-clear on ping-pong reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ppReset_q   <= 1'b0;
         modEnable_q <= 1'b0;
         resume_q    <= 1'b0;
         suspend_q   <= 1'b0;
      end else if (ctrlWrite) begin
         ppReset_q   <= busReq.wdata[ucr_pkg::BIT_PP_RESET]; // RULE3
         modEnable_q <= busReq.wdata[ucr_pkg::BIT_MOD_ENABLE]; // RULE9
         resume_q    <= busReq.wdata[ucr_pkg::BIT_RESUME]; // RULE11
         suspend_q   <= busReq.wdata[ucr_pkg::BIT_SUSPEND]; // RULE13
      end
   end

   // Set by SETUP, cleared only by writing zero; set wins the race
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pktDisable_q <= 1'b0;
      end else if (setupToken && modEnable_q) begin
         pktDisable_q <= 1'b1; // RULE6
      end else if (ctrlWrite &&
                   !busReq.wdata[ucr_pkg::BIT_PKT_DISABLE]) begin
         pktDisable_q <= 1'b0; // RULE7
      end
   end

   // Three stages; change accepted when second and third agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         se0Sync_q <= 3'h0;
         se0Live_q <= 1'b0;
      end else begin
         se0Sync_q <= {se0Sync_q[1:0], busSe0};
         if (se0Sync_q[1] == se0Sync_q[2]) begin
            se0Live_q <= se0Sync_q[2]; // RULE19
         end
      end
   end

   // Rising edge of enable clears ping-pong indicators
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enablePrev_q <= 1'b0;
      end else begin
         enablePrev_q <= modEnable_q;
      end
   end

   always_comb begin
      readValue = 8'h00; // RULE1
      readValue[ucr_pkg::BIT_PP_RESET]    = ppReset_q;
      readValue[ucr_pkg::BIT_SE0]         = se0Live_q; // RULE5
      readValue[ucr_pkg::BIT_PKT_DISABLE] = pktDisable_q;
      readValue[ucr_pkg::BIT_MOD_ENABLE]  = modEnable_q;
      readValue[ucr_pkg::BIT_RESUME]      = resume_q;
      readValue[ucr_pkg::BIT_SUSPEND]     = suspend_q;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= ucr_pkg::CTRL_RESET;
      end else if (busReq.rd) begin
         rdata_q <= (busReq.addr == ucr_pkg::USB_CONTROL_OFS) ?
                    readValue : ucr_pkg::UNMAPPED_READ;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata = rdata_q;

   // Controls inert while disabled, apart from packetDisable, which keeps its level
   always_comb begin
      ctrl.moduleEnable      = modEnable_q; // RULE9
      ctrl.ppPointerReset    = modEnable_q && ppReset_q &&
                               (pingpongMode != ucr_pkg::PPB_NONE); // RULE2 RULE4
      ctrl.packetDisable     = pktDisable_q; // RULE6
      ctrl.resumeDrive       = modEnable_q && resume_q &&
                               !suspend_q; // RULE11
      ctrl.suspendReq        = modEnable_q && suspend_q; // RULE13
      ctrl.engineClkEn       = modEnable_q && !suspend_q; // RULE13
      ctrl.xcvrIdle          = !modEnable_q || suspend_q ||
                               pktDisable_q; // RULE15
      ctrl.pullupOn          = modEnable_q && pullupEnable; // RULE17 RULE15
      ctrl.clearPpIndicators = modEnable_q && !enablePrev_q; // RULE17
   end

   // Completion events stay visible despite the lockout
   assign statusFifoReadable = statusFifoPending; // RULE8
endmodule
`default_nettype wire

/* hw/ucr_pkg.sv */
/*
 * Package for the USB control register block: register offset, bit
 * positions, reset values and the carrier structs shared by the block.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
`default_nettype none
package ucr_pkg;
   localparam int unsigned ADDR_W          = 12;
   localparam logic [11:0] USB_CONTROL_OFS = 12'hF65;

   localparam int unsigned BIT_PP_RESET    = 6;
   localparam int unsigned BIT_SE0         = 5;
   localparam int unsigned BIT_PKT_DISABLE = 4;
   localparam int unsigned BIT_MOD_ENABLE  = 3;
   localparam int unsigned BIT_RESUME      = 2;
   localparam int unsigned BIT_SUSPEND     = 1;

   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
   localparam logic [1:0]  PPB_NONE        = 2'h0;

   // Software-side request to the register
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } ucr_bus_req_t;

   // Control levels handed to the interface engine and transceiver
   typedef struct packed {
      logic moduleEnable;
      logic ppPointerReset;
      logic packetDisable;
      logic resumeDrive;
      logic suspendReq;
      logic engineClkEn;
      logic xcvrIdle;
      logic pullupOn;
      logic clearPpIndicators;
   } ucr_ctrl_t;
endpackage
`default_nettype wire

/* test/ucr_usb_control_properties.sv */
/* Checker for the USB control register ports.
   Assumes binding onto ucr_usb_control. */
`default_nettype none
module ucr_chk (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire ucr_pkg::ucr_bus_req_t busReq,
   input wire logic [7:0]            rdata,
   input wire logic                  setupToken,
   input wire logic [1:0]            pingpongMode,
   input wire ucr_pkg::ucr_ctrl_t    ctrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   rd_zero_a: assert property (
      busReq.rd |=> !rdata[7] && !rdata[0])
      else $error("unused bits read nonzero");
   pp_mode_a: assert property (
      ctrl.ppPointerReset |-> pingpongMode != 2'h0)
      else $error("pointer reset without ping-pong");
   setup_lock_a: assert property (
      setupToken && ctrl.moduleEnable |=> ctrl.packetDisable)
      else $error("setup did not lock packets");
   pkt_noset_a: assert property (
      $rose(ctrl.packetDisable) |-> $past(setupToken))
      else $error("packet lock set without setup");
   en_write_a: assert property (
      busReq.wr && busReq.addr == ucr_pkg::USB_CONTROL_OFS
      |=> ctrl.moduleEnable == $past(busReq.wdata[3]))
      else $error("enable did not follow write");
   resume_a: assert property (ctrl.resumeDrive |-> ctrl.moduleEnable)
      else $error("resume while disabled");
   susp_idle_a: assert property (
      ctrl.suspendReq
      |-> !ctrl.engineClkEn && ctrl.xcvrIdle && ctrl.moduleEnable)
      else $error("suspend state wrong");
   en_pulse_a: assert property ($rose(ctrl.moduleEnable)
      |-> ctrl.clearPpIndicators ##1 !ctrl.clearPpIndicators)
      else $error("indicator clear pulse wrong");
endmodule
bind ucr_usb_control ucr_chk i_ucr_chk (.clk(clk), .nrst(nrst),
   .busReq(busReq), .rdata(rdata), .setupToken(setupToken),
   .pingpongMode(pingpongMode), .ctrl(ctrl));
`default_nettype wire

/* test/ucr_host_model.sv */
/* Host side: SETUP pulses and bus SE0 level.
   Assumes the bench calls its tasks. */
`default_nettype none
module ucr_host_model (
   input wire logic clk,
   output var logic setupToken,
   output var logic busSe0
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      setupToken = 1'b0;
      busSe0 = 1'b0;
   end
   task automatic send_setup();
      @(posedge clk) setupToken <= 1'b1;
      @(posedge clk) setupToken <= 1'b0;
   endtask
   task automatic drive_se0(input logic v);
      @(posedge clk) busSe0 <= v;
   endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
/* Bench for the USB control register.
   Assumes the host model and the bound checker. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0, setupToken, busSe0;
   logic [1:0] ppMode = 2'h2;
   logic [7:0] rdata;
   logic fifoPend = 1'b0, fifoRd;
   ucr_pkg::ucr_bus_req_t req = '0;
   ucr_pkg::ucr_ctrl_t ctrl;
   int num_errors = 0, samples_checked = 0;
   ucr_host_model i_ucr_host_model (.clk(clk), .setupToken(setupToken),
      .busSe0(busSe0));
   ucr_usb_control i_ucr_usb_control (.clk(clk), .nrst(nrst), .busReq(req),
      .rdata(rdata), .setupToken(setupToken), .pingpongMode(ppMode),
      .pullupEnable(1'b1), .statusFifoPending(fifoPend),
      .statusFifoReadable(fifoRd), .busSe0(busSe0), .ctrl(ctrl));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk) req <= '{12'hF65, d, 1'b1, 1'b0};
      @(posedge clk) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic give_verdict();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_bits();
      wr(8'hFF);
      rd(12'hF65, 8'h4E);
      chk({7'h00, ctrl.ppPointerReset}, 8'h01);
      chk({7'h00, ctrl.engineClkEn}, 8'h00);
      @(posedge clk) ppMode <= 2'h0;
      #1 chk({7'h00, ctrl.ppPointerReset}, 8'h00);
      $display("bits done");
   endtask
   task automatic t_setup();
      wr(8'h08);
      i_ucr_host_model.send_setup();
      rd(12'hF65, 8'h18);
      wr(8'h08);
      rd(12'hF65, 8'h08);
      $display("setup done");
   endtask
   task automatic t_se0();
      i_ucr_host_model.drive_se0(1'b1);
      repeat (8) @(posedge clk);
      rd(12'hF65, 8'h28);
      rd(12'h123, 8'h00);
      i_ucr_host_model.drive_se0(1'b0);
      repeat (8) @(posedge clk);
      rd(12'hF65, 8'h08);
      $display("se0 done");
   endtask
   task automatic t_reset();
      @(posedge clk) nrst <= 1'b0;
      #1 chk({6'h00, ctrl.xcvrIdle, ctrl.moduleEnable}, 8'h02);
      @(posedge clk) nrst <= 1'b1;
      rd(12'hF65, 8'h00);
      $display("reset done");
   endtask
   task automatic t_ctrl();
      wr(8'h08);
      #1 chk({7'h00, ctrl.clearPpIndicators}, 8'h01);
      chk({7'h00, ctrl.pullupOn}, 8'h01);
      @(posedge clk);
      #1 chk({7'h00, ctrl.clearPpIndicators}, 8'h00);
      wr(8'h0C);
      #1 chk({7'h00, ctrl.resumeDrive}, 8'h01);
      // Hold cut short; the real span would blow the cycle budget
      repeat (4) @(posedge clk);
      wr(8'h0A);
      #1 chk({6'h00, ctrl.suspendReq, ctrl.engineClkEn}, 8'h02);
      chk({6'h00, ctrl.xcvrIdle, ctrl.pullupOn}, 8'h03);
      chk({7'h00, ctrl.resumeDrive}, 8'h00);
      @(posedge clk) fifoPend <= 1'b1;
      #1 chk({7'h00, fifoRd}, 8'h01);
      wr(8'h08);
      wr(8'h00);
      #1 chk({6'h00, ctrl.moduleEnable, ctrl.pullupOn}, 8'h00);
      $display("ctrl done");
   endtask
   initial begin
      #100us num_errors++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_bits();
      t_setup();
      t_se0();
      t_reset();
      t_ctrl();
      give_verdict();
   end
endmodule
`default_nettype wire
